//--- lpc_defines.svh
// constants of the low-power clock-loss controller
`ifndef LPC_DEFINES_SVH
`define LPC_DEFINES_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define LPC_OFF_CTRL 12'h000
`define LPC_OFF_STATUS 12'h004
`define LPC_OFF_MASK 12'h008
`define LPC_OFF_STATE 12'h00C

// ---------------------------------------------------------------
// control fields
// ---------------------------------------------------------------
`define LPC_CTRL_CME 0
`define LPC_CTRL_SELF_CLOCK_MODE_ENABLE 1
`define LPC_CTRL_SELF_CLOCK_INTERRUPT_ENABLE 2
`define LPC_CTRL_PLL_CLOCK_SELECT 3
`define LPC_CTRL_PSTOP 4
`define LPC_CTRL_RTI_RUN 5
`define LPC_CTRL_WDT_RUN 6
`define LPC_CTRL_RESET 8'h00
`define LPC_CTRL_MASK 8'h7F

// ---------------------------------------------------------------
// status and mask fields
// ---------------------------------------------------------------
`define LPC_ST_SCM_FLAG 0
`define LPC_ST_CM_RESET 1
`define LPC_ST_WAKE 2
`define LPC_STATUS_RESET 3'h0
`define LPC_MASK_RESET 3'h0

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define LPC_QC_OSC_CYCLES 13'h1000

// ---------------------------------------------------------------
// bus answers
// ---------------------------------------------------------------
`define LPC_RESP_OKAY 2'h0
`define LPC_RESP_SLVERR 2'h2

`endif

//--- lpc_pkg.sv
// types of the low-power clock-loss controller
`default_nettype none

package lpc_pkg;

	typedef enum logic [2:0] {
		LPC_RUN,
		LPC_SEL_OSC,
		LPC_PLL_OFF,
		LPC_CORE_OFF,
		LPC_SYS_OFF,
		LPC_WAIT,
		LPC_PSTOP,
		LPC_FSTOP
	} lpc_state_t;

endpackage

`default_nettype wire

//--- lpc_low_power_ctrl.sv
// low-power entry, clock-loss handling and wake-up of the clock and reset generator
//
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`default_nettype none

`include "lpc_defines.svh"

module lpc_low_power_ctrl
	import lpc_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_srst,
	input wire logic i_wait_req,
	input wire logic i_stop_req,
	input wire logic i_wake_irq,
	input wire logic i_ext_reset_n,
	input wire logic i_clock_fail,
	input wire logic i_osc_clock,
	input wire logic [11:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [11:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	output logic o_irq,
	output logic o_wakeup,
	output logic o_reset_start,
	output logic o_cm_reset,
	output logic o_self_clock_mode,
	output logic o_check_active,
	output logic o_sysclk_is_pll,
	output logic o_pll_enable,
	output logic o_voltage_regulator_low_power_req,
	output logic o_osc_enable,
	output logic o_core_clock_enable,
	output logic o_system_clock_enable,
	output logic o_rti_clock_enable,
	output logic o_wdt_clock_enable,
	output logic o_count_hold
);

	// ---------------------------------------------------------------
	// register decode
	// ---------------------------------------------------------------
	// returns {hit, index}
	function automatic logic [2:0] reg_sel(input logic [11:0] a);
		logic [2:0] r;
		r = 3'h0;
		case (a)
			`LPC_OFF_CTRL: r = 3'h4;
			`LPC_OFF_STATUS: r = 3'h5;
			`LPC_OFF_MASK: r = 3'h6;
			`LPC_OFF_STATE: r = 3'h7;
			default: r = 3'h0;
		endcase
		return r;
	endfunction

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	// bit 0 external reset, 1 clock fail, 2 oscillator clock
	logic [2:0] pin_raw;
	logic [2:0] sync1_reg;
	logic [2:0] sync2_reg;
	logic [2:0] sync3_reg;
	logic [2:0] pin_reg;
	logic [2:0] pin_d_reg;

	assign pin_raw = {i_osc_clock, i_clock_fail, ~i_ext_reset_n};

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			sync1_reg <= 3'h0;
			sync2_reg <= 3'h0;
			sync3_reg <= 3'h0;
		end else begin
			sync1_reg <= pin_raw;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	// a change counts once stages two and three agree
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_filt
			always_ff @(posedge i_clock) begin
				if (i_srst) begin
					pin_reg[g] <= 1'b0;
					pin_d_reg[g] <= 1'b0;
				end else begin
					if (sync2_reg[g] == sync3_reg[g]) begin
						pin_reg[g] <= sync3_reg[g];
					end
					pin_d_reg[g] <= pin_reg[g];
				end
			end
		end
	endgenerate

	logic ext_evt;
	logic fail;
	logic fail_rise;
	logic osc_tick;

	assign ext_evt = pin_reg[0] & ~pin_d_reg[0];
	assign fail = pin_reg[1];
	assign fail_rise = pin_reg[1] & ~pin_d_reg[1];
	assign osc_tick = pin_reg[2] & ~pin_d_reg[2];

	// ---------------------------------------------------------------
	// registers and state
	// ---------------------------------------------------------------
	logic [7:0] ctrl_reg;
	logic [2:0] status_reg;
	logic [2:0] mask_reg;
	lpc_state_t state_reg;
	lpc_state_t state_next;
	logic is_stop_reg;
	logic scm_reg;
	logic [12:0] qc_cnt_reg;

	logic clock_monitor_enable;
	logic self_clock_mode_enable;
	logic self_clock_interrupt_enable;
	logic pstop_sel;
	assign clock_monitor_enable = ctrl_reg[`LPC_CTRL_CME];
	assign self_clock_mode_enable = ctrl_reg[`LPC_CTRL_SELF_CLOCK_MODE_ENABLE];
	assign self_clock_interrupt_enable = ctrl_reg[`LPC_CTRL_SELF_CLOCK_INTERRUPT_ENABLE];
	assign pstop_sel = ctrl_reg[`LPC_CTRL_PSTOP];

	// ---------------------------------------------------------------
	// clock-loss events
	// ---------------------------------------------------------------
	logic asleep;
	logic full_stop;
	logic loss;
	logic cm_evt;
	logic scm_evt;
	logic qc_good;
	logic exit_evt;

	assign asleep = (state_reg == LPC_WAIT) || (state_reg == LPC_PSTOP);
	assign full_stop = state_reg == LPC_FSTOP;
	// full stop has no monitor at all
	assign loss = fail_rise & clock_monitor_enable & ~full_stop;
	assign cm_evt = loss & ~self_clock_mode_enable;
	assign scm_evt = loss & self_clock_mode_enable;
	assign qc_good = scm_reg && !fail && !full_stop && osc_tick &&
		(qc_cnt_reg == `LPC_QC_OSC_CYCLES - 13'h0001);
	// without its irq a self-clock event keeps the device asleep
	assign exit_evt = (asleep && (i_wake_irq || cm_evt || (scm_evt && self_clock_interrupt_enable))) ||
		(full_stop && i_wake_irq);

	// ---------------------------------------------------------------
	// low-power sequencer
	// ---------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			LPC_RUN: begin
				if (i_stop_req || i_wait_req) begin
					state_next = LPC_SEL_OSC;
				end
			end
			LPC_SEL_OSC: state_next = LPC_PLL_OFF;
			LPC_PLL_OFF: state_next = LPC_CORE_OFF;
			LPC_CORE_OFF: state_next = LPC_SYS_OFF;
			LPC_SYS_OFF: begin
				if (!is_stop_reg) begin
					state_next = LPC_WAIT;
				end else if (pstop_sel) begin
					state_next = LPC_PSTOP;
				end else begin
					state_next = LPC_FSTOP;
				end
			end
			LPC_WAIT, LPC_PSTOP, LPC_FSTOP: begin
				if (exit_evt) begin
					state_next = LPC_RUN;
				end
			end
			default: state_next = LPC_RUN;
		endcase
		if (ext_evt) begin
			state_next = LPC_RUN;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			state_reg <= LPC_RUN;
			is_stop_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (state_reg == LPC_RUN) begin
				is_stop_reg <= i_stop_req;
			end
		end
	end

	// ---------------------------------------------------------------
	// self-clock mode and quality checker
	// ---------------------------------------------------------------
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			scm_reg <= 1'b0;
		end else if (scm_evt) begin
			scm_reg <= 1'b1;
		end else if (qc_good) begin
			scm_reg <= 1'b0;
		end
	end

	// the count restarts on every failure, so one window must pass clean
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			qc_cnt_reg <= 13'h0000;
		end else if (!scm_reg || fail || full_stop || qc_good) begin
			qc_cnt_reg <= 13'h0000;
		end else if (osc_tick) begin
			qc_cnt_reg <= qc_cnt_reg + 13'h0001;
		end
	end

	// ---------------------------------------------------------------
	// bus slave
	// ---------------------------------------------------------------
	logic [11:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic wstrb0_reg;
	logic [2:0] wsel;
	logic wr_go;
	logic wr_ctrl;
	logic wr_status;
	logic wr_mask;
	logic [2:0] rsel;

	assign wr_go = !o_awready && !o_wready && !o_bvalid;
	assign wsel = reg_sel(awaddr_reg);
	assign wr_ctrl = wr_go && wstrb0_reg && (wsel == 3'h4);
	assign wr_status = wr_go && wstrb0_reg && (wsel == 3'h5);
	assign wr_mask = wr_go && wstrb0_reg && (wsel == 3'h6);
	assign rsel = reg_sel(i_araddr);

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_awready <= 1'b1;
			o_wready <= 1'b1;
			o_bvalid <= 1'b0;
			o_bresp <= `LPC_RESP_OKAY;
			awaddr_reg <= 12'h000;
			wdata_reg <= 32'h00000000;
			wstrb0_reg <= 1'b0;
		end else begin
			if (i_awvalid && o_awready) begin
				o_awready <= 1'b0;
				awaddr_reg <= i_awaddr;
			end
			if (i_wvalid && o_wready) begin
				o_wready <= 1'b0;
				wdata_reg <= i_wdata;
				wstrb0_reg <= i_wstrb[0];
			end
			if (wr_go) begin
				o_bvalid <= 1'b1;
				o_bresp <= wsel[2] ? `LPC_RESP_OKAY : `LPC_RESP_SLVERR;
			end
			if (o_bvalid && i_bready) begin
				o_bvalid <= 1'b0;
				o_awready <= 1'b1;
				o_wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_arready <= 1'b1;
			o_rvalid <= 1'b0;
			o_rdata <= 32'h00000000;
			o_rresp <= `LPC_RESP_OKAY;
		end else if (i_arvalid && o_arready) begin
			o_arready <= 1'b0;
			o_rvalid <= 1'b1;
			o_rresp <= rsel[2] ? `LPC_RESP_OKAY : `LPC_RESP_SLVERR;
			case (rsel)
				3'h4: o_rdata <= {24'h000000, ctrl_reg};
				3'h5: o_rdata <= {29'h00000000, status_reg};
				3'h6: o_rdata <= {29'h00000000, mask_reg};
				3'h7: o_rdata <= {26'h0000000, scm_reg, fail, state_reg, is_stop_reg};
				default: o_rdata <= 32'h00000000;
			endcase
		end else if (o_rvalid && i_rready) begin
			o_rvalid <= 1'b0;
			o_arready <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// control, status and mask
	// ---------------------------------------------------------------
	// pin reset reaches the registers through the synchroniser, not asynchronously
	always_ff @(posedge i_clock) begin
		if (i_srst || ext_evt || cm_evt) begin
			ctrl_reg <= `LPC_CTRL_RESET;
		end else begin
			if (wr_ctrl) begin
				ctrl_reg <= wdata_reg[7:0] & `LPC_CTRL_MASK;
			end
			if (state_reg == LPC_SEL_OSC) begin
				ctrl_reg[`LPC_CTRL_PLL_CLOCK_SELECT] <= 1'b0;
			end
		end
	end

	logic [2:0] st_set;
	assign st_set = {exit_evt, cm_evt, scm_evt};

	// a set in the clearing cycle wins
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			status_reg <= `LPC_STATUS_RESET;
		end else if (wr_status) begin
			status_reg <= (status_reg & ~wdata_reg[2:0]) | st_set;
		end else begin
			status_reg <= status_reg | st_set;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			mask_reg <= `LPC_MASK_RESET;
		end else if (wr_mask) begin
			mask_reg <= wdata_reg[2:0];
		end
	end

	// ---------------------------------------------------------------
	// event outputs
	// ---------------------------------------------------------------
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_irq <= 1'b0;
			o_wakeup <= 1'b0;
			o_reset_start <= 1'b0;
			o_cm_reset <= 1'b0;
		end else begin
			o_irq <= |(status_reg & mask_reg);
			o_wakeup <= exit_evt;
			o_reset_start <= ext_evt || cm_evt;
			o_cm_reset <= cm_evt && !ext_evt;
		end
	end

	// ---------------------------------------------------------------
	// clock and power outputs
	// ---------------------------------------------------------------
	logic in_stop;
	logic core_on;
	logic sys_on;
	assign in_stop = (state_reg == LPC_PSTOP) || full_stop;
	assign core_on = (state_reg == LPC_RUN) || (state_reg == LPC_SEL_OSC) ||
		(state_reg == LPC_PLL_OFF);
	assign sys_on = core_on || (state_reg == LPC_CORE_OFF);

	// registered a cycle behind the state; outside self-clock mode the pll and the core clock drop on the same edge, leaving LPC_CORE_OFF
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_self_clock_mode <= 1'b0;
			o_check_active <= 1'b0;
			o_sysclk_is_pll <= 1'b0;
			o_pll_enable <= 1'b1;
			o_voltage_regulator_low_power_req <= 1'b0;
			o_osc_enable <= 1'b1;
			o_core_clock_enable <= 1'b1;
			o_system_clock_enable <= 1'b1;
			o_rti_clock_enable <= 1'b1;
			o_wdt_clock_enable <= 1'b1;
			o_count_hold <= 1'b0;
		end else begin
			o_self_clock_mode <= scm_reg;
			o_check_active <= scm_reg && !full_stop;
			o_sysclk_is_pll <= scm_reg || ctrl_reg[`LPC_CTRL_PLL_CLOCK_SELECT];
			o_pll_enable <= (scm_reg && !full_stop) || core_on;
			o_voltage_regulator_low_power_req <= in_stop && !(scm_reg && !full_stop);
			o_osc_enable <= !full_stop;
			o_core_clock_enable <= core_on;
			o_system_clock_enable <= sys_on;
			o_rti_clock_enable <= sys_on || (state_reg == LPC_WAIT) ||
				(state_reg == LPC_PSTOP && ctrl_reg[`LPC_CTRL_RTI_RUN]);
			o_wdt_clock_enable <= sys_on || (state_reg == LPC_WAIT) ||
				(state_reg == LPC_PSTOP && ctrl_reg[`LPC_CTRL_WDT_RUN]);
			o_count_hold <= in_stop;
		end
	end

endmodule

`default_nettype wire

//--- lpc_low_power_ctrl_checker.sv
// assertions on the ports of the low-power clock-loss controller
`default_nettype none
module lpc_low_power_ctrl_checker (
	input wire logic i_clock,
	input wire logic i_srst,
	input wire logic i_ext_reset_n,
	input wire logic i_clock_fail,
	input wire logic i_bready,
	input wire logic o_bvalid,
	input wire logic [1:0] o_bresp,
	input wire logic o_wakeup,
	input wire logic o_reset_start,
	input wire logic o_cm_reset,
	input wire logic o_self_clock_mode,
	input wire logic o_sysclk_is_pll,
	input wire logic o_pll_enable,
	input wire logic o_voltage_regulator_low_power_req,
	input wire logic o_osc_enable,
	input wire logic o_core_clock_enable,
	input wire logic o_system_clock_enable,
	input wire logic o_count_hold
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_srst);
	// ---------------------------------------------------------------
	// entry steps
	// ---------------------------------------------------------------
	sequence s_core_gone;
		!o_core_clock_enable && (!o_pll_enable || o_self_clock_mode);
	endsequence
	sequence s_all_gone;
		!o_core_clock_enable && !o_system_clock_enable;
	endsequence
	AST_PLL_BEFORE_CORE: assert property ($fell(o_core_clock_enable) |-> s_core_gone)
		else $error("core clock stopped while pll still on");
	AST_CORE_BEFORE_SYS: assert property ($fell(o_system_clock_enable) |-> s_all_gone)
		else $error("system clock stopped before core clock");
	AST_OSC_FULL_STOP: assert property (!o_osc_enable |-> s_all_gone)
		else $error("oscillator off outside stop");
	AST_HOLD_STOP: assert property (o_count_hold |-> s_all_gone)
		else $error("counters held while clocks run");
	// full stop keeps the self-clock flag but still powers the regulator down
	AST_VOLTAGE_REGULATOR_STOP: assert property (o_voltage_regulator_low_power_req |->
		s_all_gone and !(o_self_clock_mode && o_osc_enable))
		else $error("regulator low power outside plain stop");
	AST_SCM_PLL: assert property (o_self_clock_mode && o_osc_enable |->
		o_pll_enable && o_sysclk_is_pll)
		else $error("self-clock mode without pll clock");
	AST_CM_PAIR: assert property (o_cm_reset |-> o_reset_start && i_clock_fail)
		else $error("monitor reset without reset start or failure");
	AST_EXT_RESET: assert property ($fell(i_ext_reset_n) |-> ##[2:12] o_reset_start)
		else $error("external reset did not start reset sequence");
	AST_WAKE_PULSE: assert property (o_wakeup |=> !o_wakeup)
		else $error("wake-up pulse longer than one cycle");
	AST_BRESP_HOLD: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
		else $error("write response dropped before handshake");
endmodule
bind lpc_low_power_ctrl lpc_low_power_ctrl_checker u_lpc_low_power_ctrl_checker (.i_clock,
	.i_srst, .i_ext_reset_n, .i_clock_fail, .i_bready, .o_bvalid, .o_bresp, .o_wakeup,
	.o_reset_start, .o_cm_reset, .o_self_clock_mode, .o_sysclk_is_pll, .o_pll_enable,
	.o_voltage_regulator_low_power_req, .o_osc_enable, .o_core_clock_enable, .o_system_clock_enable,
	.o_count_hold);
`default_nettype wire

//--- lpc_osc_model.sv
// oscillator and clock monitor model at the far side
`default_nettype none
module lpc_osc_model #(
	parameter int DIV_W = 2
) (
	input wire logic i_clock,
	input wire logic i_osc_enable,
	input wire logic i_lost,
	output logic o_osc_clock,
	output logic o_clock_fail
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [DIV_W-1:0] div_reg = '0;
	always_ff @(posedge i_clock) begin
		div_reg <= div_reg + 1'b1;
	end
	// a lost or disabled oscillator stands still
	assign o_osc_clock = i_osc_enable && !i_lost && div_reg[DIV_W-1];
	assign o_clock_fail = i_lost;
endmodule
`default_nettype wire

//--- lpc_low_power_ctrl_bench.sv
// self-checking bench of the low-power clock-loss controller
`default_nettype none
`include "lpc_defines.svh"
module lpc_low_power_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clock = 1'b0, i_srst = 1'b1, i_wait_req = 1'b0, i_stop_req = 1'b0, i_wake_irq = 1'b0;
	logic i_ext_reset_n = 1'b1, lost = 1'b0, i_clock_fail, i_osc_clock;
	logic [11:0] i_awaddr = 12'h000, i_araddr = 12'h000;
	logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
	logic [31:0] i_wdata = 32'h0, o_rdata, rd;
	logic [3:0] i_wstrb = 4'hF;
	logic [1:0] o_bresp, o_rresp, rsp;
	logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq, o_wakeup, o_reset_start;
	logic o_cm_reset, o_self_clock_mode, o_check_active, o_sysclk_is_pll, o_pll_enable;
	logic o_voltage_regulator_low_power_req, o_osc_enable, o_core_clock_enable, o_system_clock_enable;
	logic o_rti_clock_enable, o_wdt_clock_enable, o_count_hold;
	int bad_count = 0, n_tests = 0, cyc = 0, k;
	typedef struct {logic [11:0] a; logic [31:0] wd; logic [31:0] rd; logic [1:0] r;} lpc_row_t;
	lpc_row_t rows [6] = '{
		'{`LPC_OFF_CTRL, 32'h7F, 32'h7F, `LPC_RESP_OKAY},
		'{`LPC_OFF_MASK, 32'hFFFFFFFF, 32'h7, `LPC_RESP_OKAY},
		'{`LPC_OFF_STATUS, 32'h7, 32'h0, `LPC_RESP_OKAY},
		'{12'h010, 32'h1, 32'h0, `LPC_RESP_SLVERR},
		'{`LPC_OFF_CTRL, 32'h0, 32'h0, `LPC_RESP_OKAY},
		'{`LPC_OFF_MASK, 32'h0, 32'h0, `LPC_RESP_OKAY}};
	lpc_low_power_ctrl u_lpc_low_power_ctrl (.i_clock, .i_srst, .i_wait_req, .i_stop_req,
		.i_wake_irq, .i_ext_reset_n, .i_clock_fail, .i_osc_clock, .i_awaddr, .i_awvalid,
		.o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
		.i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .o_irq,
		.o_wakeup, .o_reset_start, .o_cm_reset, .o_self_clock_mode, .o_check_active,
		.o_sysclk_is_pll, .o_pll_enable, .o_voltage_regulator_low_power_req, .o_osc_enable,
		.o_core_clock_enable, .o_system_clock_enable, .o_rti_clock_enable,
		.o_wdt_clock_enable, .o_count_hold);
	lpc_osc_model u_lpc_osc_model (.i_clock, .i_osc_enable(o_osc_enable), .i_lost(lost),
		.o_osc_clock(i_osc_clock), .o_clock_fail(i_clock_fail));
	// ---------------------------------------------------------------
	// clock, timeout and closing
	// ---------------------------------------------------------------
	initial begin
		forever #2.5 i_clock = ~i_clock;
	end
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// the slowest case is one 4096-edge quality check, about 16k cycles
	always @(posedge i_clock) begin
		cyc++;
		if (cyc == 40000) begin
			bad_count++;
			stop_test();
		end
	end
	// ---------------------------------------------------------------
	// bus and compare tasks
	// ---------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic aw, w;
		aw = 1'b1;
		w = 1'b1;
		i_awaddr <= a;
		i_wdata <= d;
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		i_bready <= 1'b1;
		while (aw || w) begin
			@(posedge i_clock);
			if (aw && o_awready === 1'b1) begin
				aw = 1'b0;
				i_awvalid <= 1'b0;
			end
			if (w && o_wready === 1'b1) begin
				w = 1'b0;
				i_wvalid <= 1'b0;
			end
		end
		do @(posedge i_clock); while (o_bvalid !== 1'b1);
		rsp = o_bresp;
		i_bready <= 1'b0;
	endtask
	task automatic rc(input logic [11:0] a, input logic [31:0] e, input string nm);
		i_araddr <= a;
		i_arvalid <= 1'b1;
		i_rready <= 1'b1;
		do @(posedge i_clock); while (o_arready !== 1'b1);
		i_arvalid <= 1'b0;
		while (o_rvalid !== 1'b1) @(posedge i_clock);
		rd = o_rdata;
		rsp = o_rresp;
		i_rready <= 1'b0;
		chk(nm, e, rd);
	endtask
	task automatic rst();
		i_srst <= 1'b1;
		repeat (6) @(posedge i_clock);
		i_srst <= 1'b0;
		@(posedge i_clock);
	endtask
	task automatic req(input logic [31:0] c, input logic stp);
		wr(`LPC_OFF_CTRL, c);
		if (stp) i_stop_req <= 1'b1;
		else i_wait_req <= 1'b1;
		@(posedge i_clock);
		i_stop_req <= 1'b0;
		i_wait_req <= 1'b0;
		repeat (8) @(posedge i_clock);
	endtask
	task automatic wake();
		i_wake_irq <= 1'b1;
		for (k = 0; k < 50 && o_wakeup !== 1'b1; k++) @(posedge i_clock);
		i_wake_irq <= 1'b0;
		repeat (4) @(posedge i_clock);
	endtask
	task automatic wi(input logic [11:0] a, input logic [31:0] d, input logic e);
		wr(a, d);
		repeat (2) @(posedge i_clock);
		chk("irq", e, o_irq);
	endtask
	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		rst();
		chk("reset_outs", 11'h7E0, {o_pll_enable, o_osc_enable, o_core_clock_enable,
			o_system_clock_enable, o_rti_clock_enable, o_wdt_clock_enable, o_irq, o_wakeup,
			o_self_clock_mode, o_voltage_regulator_low_power_req, o_count_hold});
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].wd);
			chk("wr_resp", rows[i].r, rsp);
			rc(rows[i].a, rows[i].rd, "rd_data");
			chk("rd_resp", rows[i].r, rsp);
		end
		// pseudo-stop with pll selected and timer kept running
		req(32'h38, 1'b1);
		chk("stop_clk", 8'h36, {o_core_clock_enable, o_system_clock_enable, o_osc_enable,
			o_rti_clock_enable, o_wdt_clock_enable, o_voltage_regulator_low_power_req, o_count_hold,
			o_pll_enable});
		rc(`LPC_OFF_CTRL, 32'h30, "ctrl_pll_clock_select");
		wake();
		chk("wake_clk", 3'h6, {o_core_clock_enable, o_system_clock_enable, o_sysclk_is_pll});
		wr(`LPC_OFF_CTRL, 32'h08);
		repeat (2) @(posedge i_clock);
		chk("pll_back", 1'b1, o_sysclk_is_pll);
		req(32'h00, 1'b1);
		chk("full_stop", 2'h1, {o_osc_enable, o_count_hold});
		wake();
		// wait-mode loss, interrupt off, exit before recovery
		wr(`LPC_OFF_STATUS, 32'h7);
		req(32'h03, 1'b0);
		lost <= 1'b1;
		repeat (12) @(posedge i_clock);
		chk("wait_loss", 5'h1C, {o_self_clock_mode, o_pll_enable, o_sysclk_is_pll,
			o_core_clock_enable, o_wakeup});
		rc(`LPC_OFF_STATUS, 32'h1, "scm_flag");
		wake();
		chk("exit_scm", 3'h7, {o_self_clock_mode, o_sysclk_is_pll, o_core_clock_enable});
		lost <= 1'b0;
		for (k = 0; k < 20000 && o_self_clock_mode === 1'b1; k++) @(posedge i_clock);
		// one oscillator edge every four clock cycles in the model
		chk("qc_cycles", 1'b1, k >= 4 * 4095 && k <= 4 * 4096 + 16);
		// wait-mode loss with interrupt on, then mask and clear
		wr(`LPC_OFF_STATUS, 32'h7);
		wr(`LPC_OFF_MASK, 32'h1);
		req(32'h07, 1'b0);
		lost <= 1'b1;
		for (k = 0; k < 50 && o_wakeup !== 1'b1; k++) @(posedge i_clock);
		repeat (3) @(posedge i_clock);
		chk("irq_wake", 3'h7, {o_self_clock_mode, o_sysclk_is_pll, o_irq});
		wi(`LPC_OFF_MASK, 32'h0, 1'b0);
		wi(`LPC_OFF_MASK, 32'h1, 1'b1);
		wi(`LPC_OFF_STATUS, 32'h1, 1'b0);
		// pseudo-stop entered in self-clock mode, then a second loss with irq off
		req(32'h13, 1'b1);
		chk("pstop_scm", 4'h6, {o_core_clock_enable, o_check_active, o_pll_enable,
			o_voltage_regulator_low_power_req});
		lost <= 1'b0;
		repeat (8) @(posedge i_clock);
		lost <= 1'b1;
		repeat (12) @(posedge i_clock);
		chk("pstop_quiet", 2'h0, {o_core_clock_enable, o_wakeup});
		rc(`LPC_OFF_STATUS, 32'h5, "pstop_flag");
		// pin reset before recovery leaves in self-clock mode
		i_ext_reset_n <= 1'b0;
		repeat (10) @(posedge i_clock);
		i_ext_reset_n <= 1'b1;
		repeat (6) @(posedge i_clock);
		chk("ext_scm", 3'h7, {o_self_clock_mode, o_sysclk_is_pll, o_core_clock_enable});
		// full stop from self-clock mode drops the check and the pll
		req(32'h03, 1'b1);
		chk("fstop_scm", 4'h8, {o_self_clock_mode, o_check_active, o_pll_enable,
			o_osc_enable});
		wake();
		lost <= 1'b0;
		// pseudo-stop loss without self-clock mode
		rst();
		req(32'h11, 1'b1);
		lost <= 1'b1;
		for (k = 0; k < 50 && o_cm_reset !== 1'b1; k++) @(posedge i_clock);
		chk("cm_reset", 2'h3, {o_cm_reset, o_reset_start});
		rc(`LPC_OFF_CTRL, 32'h0, "cm_ctrl");
		lost <= 1'b0;
		repeat (8) @(posedge i_clock);
		// monitor off: loss ignored, then pin reset wakes
		req(32'h10, 1'b1);
		lost <= 1'b1;
		repeat (30) @(posedge i_clock);
		chk("no_detect", 2'h0, {o_self_clock_mode, o_core_clock_enable});
		lost <= 1'b0;
		i_ext_reset_n <= 1'b0;
		k = 0;
		repeat (20) begin
			@(posedge i_clock);
			if (o_reset_start === 1'b1) k = 1;
		end
		i_ext_reset_n <= 1'b1;
		repeat (6) @(posedge i_clock);
		chk("ext_reset", 2'h3, {k[0], o_core_clock_enable});
		rc(`LPC_OFF_CTRL, 32'h0, "ext_ctrl");
		stop_test();
	end
endmodule
`default_nettype wire
